// File: verilog/regfile_pkg.sv
// Shared constants, types and port numbering for the dual register file
package regfile_pkg;
    localparam int WORD_W = 32;
    localparam int HI_W = 8;
    localparam int FILL_W = 24;
    localparam int SIDES = 2;
    localparam int UNITS = 4;
    localparam int BASE_REGS = 16;
    localparam int EXT_REGS = 32;
    localparam int ADDR_W = 5;
    // Unit order inside one side
    localparam int UNIT_L = 0;
    localparam int UNIT_S = 1;
    localparam int UNIT_M = 2;
    localparam int UNIT_D = 3;
    // Read port map of the storage: 16 operand ports, then 4 long-upper ports
    localparam int RD_HI_BASE = 16;
    localparam int NUM_RD = 20;
    // Write port map: 8 unit ports, 4 long-upper, 2 multiplier-upper, 2 load
    localparam int WR_LONG_BASE = 8;
    localparam int WR_MUL_BASE = 12;
    localparam int WR_LOAD_BASE = 14;
    localparam int NUM_WR = 16;

    typedef logic [ADDR_W-1:0] reg_addr_t;
    typedef logic [WORD_W-1:0] word_t;

    // Operand read port of unit u on side s, source k (0 first, 1 second)
    function automatic int op_port(input int s, input int u, input int k);
        return (s * UNITS + u) * 2 + k;
    endfunction : op_port

    // Odd partner of a pair named by its even register
    function automatic reg_addr_t pair_odd(input reg_addr_t a);
        return {a[ADDR_W-1:1], 1'b1};
    endfunction : pair_odd
endpackage : regfile_pkg

// File: verilog/rf_port_if.sv
// Read and write port bundle between the register file top and its storage
`timescale 1ns/100ps
interface rf_port_if;
    import regfile_pkg::*;
    logic [NUM_RD-1:0] rd_file;
    reg_addr_t [NUM_RD-1:0] rd_addr;
    word_t [NUM_RD-1:0] rd_data;
    logic [NUM_WR-1:0] wr_en;
    logic [NUM_WR-1:0] wr_file;
    reg_addr_t [NUM_WR-1:0] wr_addr;
    word_t [NUM_WR-1:0] wr_data;

    modport store (input rd_file, input rd_addr, output rd_data,
                   input wr_en, input wr_file, input wr_addr, input wr_data);
    modport user (output rd_file, output rd_addr, input rd_data,
                  output wr_en, output wr_file, output wr_addr, output wr_data);
endinterface : rf_port_if

// File: verilog/rf_store.sv
// Storage array for both general register files with registered read ports
`timescale 1ns/100ps
module rf_store #(
    parameter int NREG = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Port bundle
    rf_port_if.store bus
);
    import regfile_pkg::*;

    localparam int IDX_W = $clog2(NREG);

    // Only the file sizes of the two variants are served by the address slicing
    if (NREG != BASE_REGS && NREG != EXT_REGS)
        $error("NREG must be 16 or 32");

    // Storage carries no reset, contents are undefined until written
    word_t mem_q [SIDES][NREG];

    // Every port writes in the same cycle; a later port wins on a collision
    always_ff @(posedge ref_clk)
    begin
        for (int j = 0; j < NUM_WR; j++)
        begin
            if (bus.wr_en[j])
                mem_q[bus.wr_file[j]][bus.wr_addr[j][IDX_W-1:0]] <= bus.wr_data[j];
        end
    end

    // Read data leave through a register so the top drives outputs from flops
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            bus.rd_data <= '0;
        else
        begin
            for (int i = 0; i < NUM_RD; i++)
                bus.rd_data[i] <= mem_q[bus.rd_file[i]][bus.rd_addr[i][IDX_W-1:0]];
        end
    end
endmodule : rf_store

// File: verilog/dual_regfile_crosspath.sv
// Two general register files with per-unit ports, cross paths and cross-path stall
`timescale 1ns/100ps
module dual_regfile_crosspath #(
    parameter int EXTENDED = 0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Issue of one execute packet
    input wire logic issue_valid,
    input wire regfile_pkg::reg_addr_t [1:0][3:0] first_source_operand_addr,
    input wire regfile_pkg::reg_addr_t [1:0][3:0] second_source_operand_addr,
    input wire logic [1:0][3:0] first_source_operand_cross,
    input wire logic [1:0][3:0] second_source_operand_cross,
    input wire regfile_pkg::reg_addr_t [1:0] cross_addr,
    input wire logic [1:0][1:0] long_rd,
    input wire logic ctl_move_req,
    // Unit results
    input wire logic [1:0][3:0] wr_en,
    input wire regfile_pkg::reg_addr_t [1:0][3:0] wr_addr,
    input wire regfile_pkg::word_t [1:0][3:0] wr_data,
    input wire logic [1:0][1:0] wr_long,
    input wire logic [1:0][1:0][7:0] wr_long_hi,
    input wire logic [1:0] mul_hi_en,
    input wire regfile_pkg::word_t [1:0] mul_hi_data,
    // Memory load results
    input wire logic [1:0] load_en,
    input wire regfile_pkg::reg_addr_t [1:0] load_addr,
    input wire regfile_pkg::word_t [1:0] load_data,
    // Operands
    output logic [1:0][3:0][31:0] first_source_operand,
    output logic [1:0][3:0][31:0] second_source_operand,
    output logic [1:0][1:0][7:0] long_rd_hi,
    output logic op_valid_q,
    output logic cross_stall_q,
    output logic cross_conflict_q,
    // Control register move (side-B shifter)
    output logic [31:0] ctl_move_data,
    output logic ctl_move_valid_q
);
    import regfile_pkg::*;

    localparam int NREG = (EXTENDED != 0) ? EXT_REGS : BASE_REGS;
    localparam int XP_LIMIT = (EXTENDED != 0) ? 2 : 1;

    // Only the two documented variants exist
    if (EXTENDED < 0 || EXTENDED > 1)
        $error("EXTENDED must be 0 or 1");

    // Base files decode only four address bits, so register 16 and up alias
    function automatic reg_addr_t clip(input reg_addr_t a);
        return (EXTENDED != 0) ? a : {1'b0, a[ADDR_W-2:0]};
    endfunction : clip

    // Even register of the pair that holds an address; the odd one sits just above
    function automatic reg_addr_t pair_even(input reg_addr_t a);
        return {a[ADDR_W-1:1], 1'b0};
    endfunction : pair_even

    // Which operand inputs have a cross-path multiplexer
    function automatic logic can_cross(input int u, input int k);
        if (k == 0)
            return u == UNIT_L;
        return (u != UNIT_D) || (EXTENDED != 0);
    endfunction : can_cross

    rf_port_if bus ();

    logic [1:0][3:0] xp_units;
    logic [1:0][EXT_REGS-1:0] recent_d;
    logic [1:0][EXT_REGS-1:0] recent_q;
    logic stall_d;
    logic conflict_d;

    // Units that take the side's cross operand this packet
    always_comb
    begin
        for (int s = 0; s < SIDES; s++)
        begin
            for (int u = 0; u < UNITS; u++)
            begin
                xp_units[s][u] = (first_source_operand_cross[s][u] && can_cross(u, 0)) ||
                                 (second_source_operand_cross[s][u] && can_cross(u, 1));
            end
        end
    end

    // Read addressing; a cross read always uses the side's single cross address
    always_comb
    begin
        for (int s = 0; s < SIDES; s++)
        begin
            for (int u = 0; u < UNITS; u++)
            begin
                for (int k = 0; k < 2; k++)
                begin
                    logic xsel;
                    xsel = ((k == 0) ? first_source_operand_cross[s][u] : second_source_operand_cross[s][u]) && can_cross(u, k);
                    // Two units on one side may share the cross operand
                    bus.rd_file[op_port(s, u, k)] = xsel ? 1'(1 - s) : 1'(s);
                    bus.rd_addr[op_port(s, u, k)] = xsel ? clip(cross_addr[s]) :
                        clip((k == 0) ? first_source_operand_addr[s][u] : second_source_operand_addr[s][u]);
                end
            end
            // Upper byte of a long second operand comes from the odd partner
            for (int u = 0; u < 2; u++)
            begin
                bus.rd_file[RD_HI_BASE + s * 2 + u] = bus.rd_file[op_port(s, u, 1)];
                bus.rd_addr[RD_HI_BASE + s * 2 + u] = pair_odd(bus.rd_addr[op_port(s, u, 1)]);
            end
        end
    end

    // Write ports: each unit into its own side only
    always_comb
    begin
        for (int s = 0; s < SIDES; s++)
        begin
            for (int u = 0; u < UNITS; u++)
            begin
                logic pair_wr;
                pair_wr = (u < 2) ? wr_long[s][u] : ((u == UNIT_M) && mul_hi_en[s] && (EXTENDED != 0));
                bus.wr_en[s * UNITS + u] = wr_en[s][u];
                bus.wr_file[s * UNITS + u] = 1'(s);
                // A pair write lands its low word on the even register
                bus.wr_addr[s * UNITS + u] = pair_wr ? pair_even(clip(wr_addr[s][u])) : clip(wr_addr[s][u]);
                bus.wr_data[s * UNITS + u] = wr_data[s][u];
            end
            // Long results: 8 upper bits, odd register's top 24 forced to zero
            for (int u = 0; u < 2; u++)
            begin
                bus.wr_en[WR_LONG_BASE + s * 2 + u] = wr_en[s][u] && wr_long[s][u];
                bus.wr_file[WR_LONG_BASE + s * 2 + u] = 1'(s);
                bus.wr_addr[WR_LONG_BASE + s * 2 + u] = pair_odd(clip(wr_addr[s][u]));
                bus.wr_data[WR_LONG_BASE + s * 2 + u] = {{FILL_W{1'b0}}, wr_long_hi[s][u]};
            end
            // Extended multiplier upper word through its extra port
            bus.wr_en[WR_MUL_BASE + s] = wr_en[s][UNIT_M] && mul_hi_en[s] && (EXTENDED != 0);
            bus.wr_file[WR_MUL_BASE + s] = 1'(s);
            bus.wr_addr[WR_MUL_BASE + s] = pair_odd(clip(wr_addr[s][UNIT_M]));
            bus.wr_data[WR_MUL_BASE + s] = mul_hi_data[s];
            // Memory load path, highest port numbers so a load wins a same-address collision
            bus.wr_en[WR_LOAD_BASE + s] = load_en[s];
            bus.wr_file[WR_LOAD_BASE + s] = 1'(s);
            bus.wr_addr[WR_LOAD_BASE + s] = clip(load_addr[s]);
            bus.wr_data[WR_LOAD_BASE + s] = load_data[s];
        end
    end

    rf_store #(
        .NREG(NREG)
    ) u_store (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .bus(bus.store)
    );

    // Registers written by a unit this cycle; load ports are left out on purpose
    always_comb
    begin
        recent_d = '0;
        for (int j = 0; j < WR_LOAD_BASE; j++)
        begin
            if (bus.wr_en[j])
                recent_d[bus.wr_file[j]][bus.wr_addr[j]] = 1'b1;
        end
    end

    // Freshly written map, one cycle old
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            recent_q <= '0;
        else
            recent_q <= recent_d;
    end

    // In the extended form, a cross read of a register a unit wrote last cycle costs one stall cycle; the base form never stalls
    always_comb
    begin
        stall_d = 1'b0;
        for (int s = 0; s < SIDES; s++)
        begin
            if (|xp_units[s] && recent_q[1 - s][clip(cross_addr[s])])
                stall_d = issue_valid && (EXTENDED != 0);
        end
    end

    // Too many units on one cross path flags a scheduling fault
    always_comb
    begin
        conflict_d = 1'b0;
        for (int s = 0; s < SIDES; s++)
        begin
            if ($countones(xp_units[s]) > XP_LIMIT)
                conflict_d = issue_valid;
        end
    end

    // Packet status, aligned with the registered operand data
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_valid_q <= 1'b0;
            cross_stall_q <= 1'b0;
            cross_conflict_q <= 1'b0;
        end
        else
        begin
            op_valid_q <= issue_valid && !stall_d; // Decode re-presents the packet after a stall
            cross_stall_q <= stall_d;
            cross_conflict_q <= conflict_d;
        end
    end

    // Control register move uses the side-B shifter's second operand only
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctl_move_valid_q <= 1'b0;
        else
            ctl_move_valid_q <= issue_valid && ctl_move_req && !stall_d;
    end

    // Operand outputs come straight from the storage read registers
    always_comb
    begin
        for (int s = 0; s < SIDES; s++)
        begin
            for (int u = 0; u < UNITS; u++)
            begin
                first_source_operand[s][u] = bus.rd_data[op_port(s, u, 0)];
                second_source_operand[s][u] = bus.rd_data[op_port(s, u, 1)];
            end
            // Only the low byte of the odd register is passed on
            for (int u = 0; u < 2; u++)
                long_rd_hi[s][u] = bus.rd_data[RD_HI_BASE + s * 2 + u][HI_W-1:0];
        end
        ctl_move_data = bus.rd_data[op_port(1, UNIT_S, 1)];
    end

    // Assertions

    stall_gap_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        cross_stall_q |-> !op_valid_q && !ctl_move_valid_q)
        else $error("operands marked valid during a cross-path stall");

    base_nostall_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (EXTENDED == 0) |-> !cross_stall_q)
        else $error("base variant inserted a cross-path stall");

    stall_hit_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_en[1][UNIT_L] && !wr_long[1][UNIT_L]) ##1
        (issue_valid && second_source_operand_cross[0][UNIT_S] && clip(cross_addr[0]) == $past(clip(wr_addr[1][UNIT_L])))
        |=> (cross_stall_q == (EXTENDED != 0)))
        else $error("cross read of a fresh register stall mismatch");

    load_nostall_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|load_en && wr_en == '0) |-> ##2 !cross_stall_q)
        else $error("stall inserted after a load-only write");

    share_cross_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (issue_valid && second_source_operand_cross[0][UNIT_S] && second_source_operand_cross[0][UNIT_M] && (EXTENDED != 0))
        |=> second_source_operand[0][UNIT_S] == second_source_operand[0][UNIT_M])
        else $error("two units on one side saw different cross operands");

    conflict_flag_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (issue_valid && $countones(xp_units[1]) > XP_LIMIT) |=> cross_conflict_q)
        else $error("cross-path overuse not flagged");

    conflict_clear_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (issue_valid && $countones(xp_units[0]) <= XP_LIMIT && $countones(xp_units[1]) <= XP_LIMIT)
        |=> !cross_conflict_q)
        else $error("cross-path use within the limit flagged as a conflict");

    long_fill_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_en[0] == 4'h1 && wr_long[0][UNIT_L] && !mul_hi_en[0] && !load_en[0]) ##1
        (first_source_operand_addr[0][UNIT_L] == pair_odd($past(clip(wr_addr[0][UNIT_L]))) && !first_source_operand_cross[0][UNIT_L])
        |=> first_source_operand[0][UNIT_L] == {{FILL_W{1'b0}}, $past(wr_long_hi[0][UNIT_L], 2)})
        else $error("long write did not zero-fill the odd register");

    pair_hi_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!first_source_operand_cross[1][UNIT_S] && !second_source_operand_cross[1][UNIT_S] &&
        clip(first_source_operand_addr[1][UNIT_S]) == pair_odd(clip(second_source_operand_addr[1][UNIT_S])))
        |=> long_rd_hi[1][UNIT_S] == first_source_operand[1][UNIT_S][HI_W-1:0])
        else $error("long upper byte not taken from the odd partner");

    ctl_move_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        ctl_move_valid_q |-> $past(issue_valid && ctl_move_req) && op_valid_q)
        else $error("control move valid without a request");
endmodule : dual_regfile_crosspath

// File: testbench/exec_units.sv
// Behavioural model of the functional units and load paths that write the files
`timescale 1ns/100ps
module exec_units (
    // Clock
    input wire logic ref_clk,
    // Unit results
    output logic [1:0][3:0] wr_en,
    output regfile_pkg::reg_addr_t [1:0][3:0] wr_addr,
    output regfile_pkg::word_t [1:0][3:0] wr_data,
    output logic [1:0][1:0] wr_long,
    output logic [1:0][1:0][7:0] wr_long_hi,
    output logic [1:0] mul_hi_en,
    output regfile_pkg::word_t [1:0] mul_hi_data,
    // Load results
    output logic [1:0] load_en,
    output regfile_pkg::reg_addr_t [1:0] load_addr,
    output regfile_pkg::word_t [1:0] load_data
);
    import regfile_pkg::*;
    typedef struct packed {
        logic [1:0][3:0] en;
        reg_addr_t [1:0][3:0] wa;
        word_t [1:0][3:0] wd;
        logic [1:0][1:0] lg;
        logic [1:0][1:0][7:0] lh;
        logic [1:0] me;
        word_t [1:0] md;
        logic [1:0] le;
        reg_addr_t [1:0] la;
        word_t [1:0] ldd;
    } wr_req_s;
    wr_req_s st = '0;
    wr_req_s now = '0;
    // Staged requests go out whole at the next edge and last one cycle
    always @(posedge ref_clk)
    begin
        now <= st;
        st.en = '0;
        st.lg = '0;
        st.me = '0;
        st.le = '0;
        // Idle data flips so a stale word is never mistaken for a write
        st.wd = ~st.wd;
        st.md = ~st.md;
        st.ldd = ~st.ldd;
    end
    // Every unit owns its port, so all eight may be staged in one cycle
    task automatic put_word(input int s, input int u, input reg_addr_t a, input word_t d,
                            input logic lg, input logic [7:0] hi);
        st.en[s][u] = 1'b1;
        st.wa[s][u] = lg ? {a[4:1], 1'b0} : a;
        st.wd[s][u] = d;
        if (u < 2)
        begin
            st.lg[s][u] = lg;
            st.lh[s][u] = hi;
        end
    endtask : put_word
    // Multiplier pair result named by its even register
    task automatic put_mul(input int s, input reg_addr_t a, input word_t lo, input word_t hi);
        put_word(s, UNIT_M, {a[4:1], 1'b0}, lo, 1'b0, 8'h00);
        st.me[s] = 1'b1;
        st.md[s] = hi;
    endtask : put_mul
    task automatic put_load(input int s, input reg_addr_t a, input word_t d);
        st.le[s] = 1'b1;
        st.la[s] = a;
        st.ldd[s] = d;
    endtask : put_load
    assign wr_en = now.en;
    assign wr_addr = now.wa;
    assign wr_data = now.wd;
    assign wr_long = now.lg;
    assign wr_long_hi = now.lh;
    assign mul_hi_en = now.me;
    assign mul_hi_data = now.md;
    assign load_en = now.le;
    assign load_addr = now.la;
    assign load_data = now.ldd;
endmodule : exec_units

// File: testbench/tb_dual_regfile_crosspath.sv
// Self-checking bench for the dual register file in its extended form
`timescale 1ns/100ps
module tb_dual_regfile_crosspath;
    import regfile_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic issue_valid = 1'b0;
    reg_addr_t [1:0][3:0] first_source_operand_addr = '0, second_source_operand_addr = '0, n1, n2;
    logic [1:0][3:0] first_source_operand_cross = '0, second_source_operand_cross = '0, nc1, nc2;
    reg_addr_t [1:0] cross_addr = '0, nca;
    logic [1:0][1:0] long_rd = '0, nlr;
    logic ctl_move_req = 1'b0, nmv;
    logic [1:0][3:0] wr_en;
    reg_addr_t [1:0][3:0] wr_addr;
    word_t [1:0][3:0] wr_data;
    logic [1:0][1:0] wr_long;
    logic [1:0][1:0][7:0] wr_long_hi, long_rd_hi;
    logic [1:0] mul_hi_en, load_en;
    word_t [1:0] mul_hi_data, load_data;
    reg_addr_t [1:0] load_addr;
    logic [1:0][3:0][31:0] first_source_operand, second_source_operand;
    logic op_valid_q, cross_stall_q, cross_conflict_q, ctl_move_valid_q;
    logic [31:0] ctl_move_data;
    logic b_stall, b_conf;
    word_t mem [2][32];
    int err_total = 0;
    int checks_done = 0;
    int seed = 37;
    word_t d;
    // Clock at 25 MHz
    always #20 ref_clk = ~ref_clk;
    dual_regfile_crosspath #(.EXTENDED(1)) u_dual_regfile_crosspath (
        .ref_clk(ref_clk), .rst_n(rst_n), .issue_valid(issue_valid), .first_source_operand_addr(first_source_operand_addr),
        .second_source_operand_addr(second_source_operand_addr), .first_source_operand_cross(first_source_operand_cross), .second_source_operand_cross(second_source_operand_cross), .cross_addr(cross_addr),
        .long_rd(long_rd), .ctl_move_req(ctl_move_req), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_long(wr_long), .wr_long_hi(wr_long_hi), .mul_hi_en(mul_hi_en), .mul_hi_data(mul_hi_data),
        .load_en(load_en), .load_addr(load_addr), .load_data(load_data),
        .first_source_operand(first_source_operand), .second_source_operand(second_source_operand),
        .long_rd_hi(long_rd_hi), .op_valid_q(op_valid_q), .cross_stall_q(cross_stall_q),
        .cross_conflict_q(cross_conflict_q), .ctl_move_data(ctl_move_data), .ctl_move_valid_q(ctl_move_valid_q));
    // Base form on the same stimulus: it never stalls and allows one cross unit per side
    dual_regfile_crosspath #(.EXTENDED(0)) u_dual_regfile_crosspath_base (
        .ref_clk(ref_clk), .rst_n(rst_n), .issue_valid(issue_valid), .first_source_operand_addr(first_source_operand_addr),
        .second_source_operand_addr(second_source_operand_addr), .first_source_operand_cross(first_source_operand_cross), .second_source_operand_cross(second_source_operand_cross), .cross_addr(cross_addr),
        .long_rd(long_rd), .ctl_move_req(ctl_move_req), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_long(wr_long), .wr_long_hi(wr_long_hi), .mul_hi_en(mul_hi_en), .mul_hi_data(mul_hi_data),
        .load_en(load_en), .load_addr(load_addr), .load_data(load_data), .first_source_operand(),
        .second_source_operand(), .long_rd_hi(), .op_valid_q(), .cross_stall_q(b_stall),
        .cross_conflict_q(b_conf), .ctl_move_data(), .ctl_move_valid_q());
    exec_units u_exec_units (
        .ref_clk(ref_clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_long(wr_long),
        .wr_long_hi(wr_long_hi), .mul_hi_en(mul_hi_en), .mul_hi_data(mul_hi_data), .load_en(load_en),
        .load_addr(load_addr), .load_data(load_data));
    // Comparison of words and of flags
    task automatic chk32(input string n, input word_t e, input word_t g);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk32
    task automatic chk1(input string n, input logic e, input logic g);
        chk32(n, {31'h0, e}, {31'h0, g});
    endtask : chk1
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    // Operand a unit should see: k 0 first, 1 second, 2 odd partner of second
    function automatic word_t exp_src(input int s, input int u, input int k);
        logic x;
        reg_addr_t a;
        x = (k == 0) ? (first_source_operand_cross[s][u] && u == UNIT_L) : second_source_operand_cross[s][u];
        a = x ? cross_addr[s] : (k == 0 ? first_source_operand_addr[s][u] : second_source_operand_addr[s][u]);
        if (k == 2)
            a[0] = 1'b1;
        return mem[x ? 1 - s : s][a];
    endfunction : exp_src
    // Base form: L counts once, D has no cross input, more than one unit per side is a conflict
    function automatic logic base_conf();
        int n;
        base_conf = 1'b0;
        for (int s = 0; s < 2; s++)
        begin
            n = (first_source_operand_cross[s][UNIT_L] || second_source_operand_cross[s][UNIT_L]) + second_source_operand_cross[s][UNIT_S] + second_source_operand_cross[s][UNIT_M];
            if (n > 1)
                base_conf = 1'b1;
        end
    endfunction : base_conf
    // Writes go to the model and to the expected image together
    task automatic w_word(input int s, input int u, input reg_addr_t a, input word_t v, input logic lg,
                          input logic [7:0] hi);
        u_exec_units.put_word(s, u, a, v, lg, hi);
        mem[s][lg ? {a[4:1], 1'b0} : a] = v;
        if (lg)
            mem[s][{a[4:1], 1'b1}] = {24'h0, hi};
    endtask : w_word
    task automatic rnd_pkt();
        n1 = 40'({$random(seed), $random(seed)});
        n2 = 40'({$random(seed), $random(seed)});
        nca = 10'($random(seed));
        nlr = 4'($random(seed));
        nmv = 1'($random(seed));
        nc1 = '0;
        nc2 = '0;
    endtask : rnd_pkt
    // Present a packet, hold it through any stall, then compare what comes back
    task automatic rd(input logic stall, input logic conf, input logic full);
        int i;
        @(posedge ref_clk);
        issue_valid <= 1'b1;
        first_source_operand_addr <= n1;
        second_source_operand_addr <= n2;
        first_source_operand_cross <= nc1;
        second_source_operand_cross <= nc2;
        cross_addr <= nca;
        long_rd <= nlr;
        ctl_move_req <= nmv;
        for (i = 0; i < 4; i++)
        begin
            @(posedge ref_clk);
            #1;
            if (i == 0)
            begin
                chk1("stall", stall, cross_stall_q);
                chk1("conflict", conf, cross_conflict_q);
                chk1("base stall", 1'b0, b_stall);
                chk1("base conflict", base_conf(), b_conf);
            end
            if (op_valid_q === 1'b1)
                break;
        end
        if (i == 4)
        begin
            err_total++;
            close_out();
        end
        chk1("retry count", stall, i == 1);
        for (int s = 0; s < 2 && full; s++)
            for (int u = 0; u < 4; u++)
            begin
                chk32("first", exp_src(s, u, 0), first_source_operand[s][u]);
                chk32("second", exp_src(s, u, 1), second_source_operand[s][u]);
                d = exp_src(s, u, 2);
                if (u < 2)
                    chk32("long upper", {24'h0, d[7:0]}, {24'h0, long_rd_hi[s][u]});
            end
        chk1("move valid", ctl_move_req, ctl_move_valid_q);
        if (ctl_move_req && full)
            chk32("move data", exp_src(1, UNIT_S, 1), ctl_move_data);
        @(posedge ref_clk);
        issue_valid <= 1'b0;
        ctl_move_req <= 1'b0;
        // Step off the edge so the next staged write never races the partner model
        #1;
    endtask : rd
    // Main sequence
    initial
    begin
        repeat (3) @(posedge ref_clk);
        chk1("reset valid", 1'b0, op_valid_q);
        rst_n <= 1'b1;
        #1;
        // All eight units write every cycle until both files are full
        for (int r = 0; r < 8; r++)
        begin
            for (int s = 0; s < 2; s++)
                for (int u = 0; u < 4; u++)
                    w_word(s, u, 5'(r * 4 + u), $random(seed), 1'b0, 8'h00);
            @(posedge ref_clk);
            #1;
        end
        repeat (24)
        begin
            rnd_pkt();
            rd(1'b0, 1'b0, 1'b1);
        end
        $display("test fill and read done");
        // Two units share each side's cross operand; L takes it on both sources
        rnd_pkt();
        nc2[0][UNIT_S] = 1'b1;
        nc2[0][UNIT_M] = 1'b1;
        nc1[1][UNIT_L] = 1'b1;
        nc2[1][UNIT_L] = 1'b1;
        nc2[1][UNIT_D] = 1'b1;
        rd(1'b0, 1'b0, 1'b1);
        rnd_pkt();
        nc2[0][2:0] = 3'h7;
        nc2[1][3:1] = 3'h7;
        rd(1'b0, 1'b1, 1'b0);
        $display("test cross paths done");
        // Multiplier pairs, then long results read back in the very next cycle
        for (int s = 0; s < 2; s++)
        begin
            u_exec_units.put_mul(s, 5'h1a, 32'h01234567 + s, 32'hfedcba98 - s);
            mem[s][26] = 32'h01234567 + s;
            mem[s][27] = 32'hfedcba98 - s;
        end
        @(posedge ref_clk);
        #1;
        w_word(0, UNIT_L, 5'h06, $random(seed), 1'b1, 8'h5a);
        w_word(1, UNIT_S, 5'h1d, $random(seed), 1'b1, 8'ha5);
        @(posedge ref_clk);
        rnd_pkt();
        n1[0] = {5'h1b, 5'h1a, 5'h07, 5'h07};
        n1[1] = {5'h1b, 5'h1a, 5'h1d, 5'h1c};
        n2[1][UNIT_S] = 5'h1c;
        rd(1'b0, 1'b0, 1'b1);
        $display("test pairs done");
        // Fresh unit writes stall a cross read; fresh loads do not
        for (int s = 0; s < 2; s++)
        begin
            w_word(1 - s, UNIT_L, 5'(s + 9), $random(seed), 1'b0, 8'h00);
            @(posedge ref_clk);
            rnd_pkt();
            nc2[s][UNIT_S] = 1'b1;
            nca[s] = 5'(s + 9);
            rd(1'b1, 1'b0, 1'b1);
            d = $random(seed);
            u_exec_units.put_load(1 - s, 5'(s + 20), d);
            mem[1 - s][s + 20] = d;
            @(posedge ref_clk);
            rnd_pkt();
            nc2[s][UNIT_M] = 1'b1;
            nca[s] = 5'(s + 20);
            rd(1'b0, 1'b0, 1'b1);
        end
        $display("test cross stall done");
        close_out();
    end
endmodule : tb_dual_regfile_crosspath
